// ==== inc/ep0_pkg.sv ====
// Constants, codes and register map of the endpoint-zero control engine
//------------------------------------------------------------------
//------------------------------------------------------------------
package ep0_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_REQ   = 12'h000; // request flags, write one clears
  localparam logic [11:0] OFS_EN    = 12'h004; // request enables
  localparam logic [11:0] OFS_CS    = 12'h008; // stall and hold
  localparam logic [11:0] OFS_FNA   = 12'h00c; // function address, read only
  localparam logic [11:0] OFS_INBC  = 12'h010; // IN byte count, write arms
  localparam logic [11:0] OFS_OUTBC = 12'h014; // OUT byte count
  localparam logic [11:0] OFS_VALID = 12'h018; // valid bits, fixed
  localparam logic [11:0] OFS_DPTR  = 12'h01c; // setup data pointer
  localparam logic [11:0] OFS_CFG   = 12'h020; // request routing
  localparam logic [6:0]  SBUF_HI   = 7'h02;   // setup buffer at 0x040..0x05c
  localparam logic [3:0]  IBUF_PG   = 4'h1;    // IN buffer at 0x100..0x1fc
  localparam logic [3:0]  OBUF_PG   = 4'h2;    // OUT buffer at 0x200..0x2fc
  // Field positions
  localparam int B_TOK  = 0;
  localparam int B_DAV  = 1;
  localparam int B_STALL = 0;
  localparam int B_HOLD = 1;
  localparam int B_PROC = 0;
  localparam logic [1:0] VALID_BITS = 2'h3;
  // Setup packet layout
  localparam logic [3:0] SETUP_LEN = 4'h8;
  localparam int SB_TYPE = 0;
  localparam int SB_REQ  = 1;
  localparam int SB_VALL = 2;
  localparam int SB_LENL = 6;
  localparam int SB_LENH = 7;
  localparam int TYPE_DIR = 7;
  localparam logic [1:0] TYPE_VENDOR  = 2'h2;
  localparam logic [7:0] TYPE_STD_DEV = 8'h00;
  localparam logic [7:0] REQ_SET_ADDR = 8'h05;
  localparam logic [7:0] REQ_FW_LOAD  = 8'ha0;
  localparam logic [3:0] EP_ZERO      = 4'h0;
  // Token kinds from the packet engine
  typedef enum logic [1:0] {
    TOK_NONE  = 2'h0,
    TOK_OUT   = 2'h1,
    TOK_IN    = 2'h2,
    TOK_SETUP = 2'h3
  } tok_e;
  // Answers to the packet engine
  typedef enum logic [1:0] {
    HS_ACK   = 2'h0,
    HS_NAK   = 2'h1,
    HS_STALL = 2'h2,
    HS_DATA  = 2'h3
  } hs_e;
endpackage

// ==== logic/req_flag.sv ====
// Sticky flag cell: hardware sets, writer clears, set wins
`timescale 1ns/1ps
module req_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_i,   // Hardware event
  input  wire logic clr_i,   // Write-one clear
  input  wire logic en_i,    // Request enable
  output logic      flag_o,  // Sticky state
  output logic      irq_o    // Gated request
);
  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef struct packed {
    logic q;
  } flag_s;
  flag_s s_r, s_nxt;

  // Set beats a clear in the same cycle so no event is lost
  always_comb begin
    s_nxt = s_r;
    if (set_i) begin
      s_nxt.q = 1'b1;
    end else if (clr_i) begin
      s_nxt.q = 1'b0;
    end
  end

  // Register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag_o = s_r.q;
  assign irq_o  = s_r.q & en_i;
endmodule // req_flag

// ==== logic/ep0_ctrl.sv ====
// Endpoint-zero control-transfer engine with APB register slave
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module ep0_ctrl #(
  parameter int BUF_DEPTH = 64   // Data buffer bytes per direction
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  // APB slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // Packet engine side
  input  wire logic           tok_stb,
  input  wire ep0_pkg::tok_e  tok_kind,
  input  wire logic [3:0]     tok_ep,
  input  wire logic           rx_stb,
  input  wire logic [7:0]     rx_byte,
  input  wire logic           pkt_end_stb,
  input  wire logic           pkt_ok,
  input  wire logic [5:0]     tx_idx,
  output logic [7:0]          tx_byte,
  output logic                hs_stb,
  output ep0_pkg::hs_e        hs_code,
  output logic [6:0]          tx_len,
  // Request handlers and interrupts
  output logic                fw_load_stb,
  output logic                auto_req_stb,
  output logic [63:0]         setup_word,
  output logic [6:0]          fn_addr,
  output logic [15:0]         dptr_addr,
  output logic                dptr_go,
  output logic                irq_setup_token,
  output logic                irq_setup_data
);
  import ep0_pkg::*;

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SETUP = 3'b010,
    ST_OUT   = 3'b100
  } ctl_state_e;

  typedef struct packed {
    ctl_state_e               st;
    logic [6:0]               idx;       // Byte index in packet
    logic [7:0][7:0]          sbuf;      // Setup buffer
    logic [BUF_DEPTH-1:0][7:0] ibuf;     // IN data buffer
    logic [BUF_DEPTH-1:0][7:0] obuf;     // OUT data buffer
    logic [6:0]               in_len;
    logic [6:0]               out_len;
    logic                     in_arm;
    logic                     out_arm;
    logic                     stall;
    logic                     proc;      // processor_handles_requests
    logic [1:0]               en;
    logic [15:0]              dptr;
    logic                     dptr_go;
    logic [6:0]               function_address_reg;
    logic [6:0]               addr_pend;
    logic                     addr_vld;
    logic                     data_stage;
    logic                     dir_in;
    logic                     out_is_data;
    logic                     hs_stb;
    hs_e                      hs_code;
    logic [6:0]               tx_len;
    logic                     fw_stb;
    logic                     auto_stb;
    logic [31:0]              prdata;
    logic [7:0]               tx_byte;
  } ep0_s;

  ep0_s s_r, s_nxt;

  logic        set_tok, set_dav, set_hold;  // Flag events
  logic        clr_tok, clr_dav, clr_hold;  // Flag clears
  logic        tok_q, dav_q, hold_q;        // Flag states
  logic        wr, acc;                     // APB access phase
  logic        hit;                         // Address decodes
  logic [31:0] rd_word;                     // Read mux
  logic [15:0] wlen;                        // Setup length field

  assign acc  = psel & penable;
  assign wr   = acc & pwrite;
  assign wlen = {s_r.sbuf[SB_LENH], s_r.sbuf[SB_LENL]};

  //----------------------------------------------------------------
  // Flag cells
  //----------------------------------------------------------------
  req_flag u_tok (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (set_tok),
    .clr_i   (clr_tok),
    .en_i    (s_r.en[B_TOK]),
    .flag_o  (tok_q),
    .irq_o   (irq_setup_token)
  );
  req_flag u_dav (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (set_dav),
    .clr_i   (clr_dav),
    .en_i    (s_r.en[B_DAV]),
    .flag_o  (dav_q),
    .irq_o   (irq_setup_data)
  );
  req_flag u_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (set_hold),
    .clr_i   (clr_hold),
    .en_i    (1'b0),
    .flag_o  (hold_q),
    .irq_o   ()
  );

  //----------------------------------------------------------------
  // Read mux and decode
  //----------------------------------------------------------------
  // Word registers first, then the three byte buffers
  always_comb begin
    rd_word = '0;
    hit     = 1'b1;
    unique case (paddr)
      OFS_REQ:   rd_word = {30'h0, dav_q, tok_q};
      OFS_EN:    rd_word = {30'h0, s_r.en};
      OFS_CS:    rd_word = {30'h0, hold_q, s_r.stall};
      OFS_FNA:   rd_word = {25'h0, s_r.function_address_reg};
      OFS_INBC:  rd_word = {25'h0, s_r.in_len};
      OFS_OUTBC: rd_word = {25'h0, s_r.out_len};
      OFS_VALID: rd_word = {30'h0, VALID_BITS};
      OFS_DPTR:  rd_word = {16'h0, s_r.dptr};
      OFS_CFG:   rd_word = {31'h0, s_r.proc};
      default: begin
        if (paddr[11:5] == SBUF_HI) begin
          rd_word = {24'h0, s_r.sbuf[paddr[4:2]]};
        end else if (paddr[11:8] == IBUF_PG) begin
          rd_word = {24'h0, s_r.ibuf[paddr[7:2]]};
        end else if (paddr[11:8] == OBUF_PG) begin
          rd_word = {24'h0, s_r.obuf[paddr[7:2]]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  //----------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------
  // Bus writes first; link events after so hardware wins a tie
  always_comb begin
    s_nxt    = s_r;
    set_tok  = 1'b0;
    set_dav  = 1'b0;
    set_hold = 1'b0;
    clr_tok  = 1'b0;
    clr_dav  = 1'b0;
    clr_hold = 1'b0;
    s_nxt.hs_stb   = 1'b0;
    s_nxt.fw_stb   = 1'b0;
    s_nxt.auto_stb = 1'b0;
    s_nxt.dptr_go  = 1'b0;
    s_nxt.tx_byte  = s_r.ibuf[tx_idx];
    // Read data latched in setup phase, so prdata is a flop
    if (psel && !penable) begin
      s_nxt.prdata = rd_word;
    end
    // Register writes
    if (wr) begin
      unique case (paddr)
        OFS_REQ: begin
          clr_tok = pwdata[B_TOK];
          clr_dav = pwdata[B_DAV];
        end
        OFS_EN: s_nxt.en = pwdata[1:0];
        OFS_CS: begin
          s_nxt.stall = pwdata[B_STALL];
          clr_hold    = pwdata[B_HOLD];
        end
        OFS_INBC: begin
          s_nxt.in_len = pwdata[6:0];
          s_nxt.in_arm = 1'b1;
        end
        OFS_OUTBC: s_nxt.out_arm = 1'b1;
        OFS_DPTR: begin
          s_nxt.dptr    = pwdata[15:0];
          s_nxt.dptr_go = 1'b1;
        end
        OFS_CFG: s_nxt.proc = pwdata[B_PROC];
        default: begin
          if (paddr[11:8] == IBUF_PG) begin
            s_nxt.ibuf[paddr[7:2]] = pwdata[7:0];
          end
        end
      endcase
    end
    // Tokens for endpoint zero
    if (tok_stb && tok_ep == EP_ZERO) begin
      unique case (tok_kind)
        TOK_SETUP: begin
          set_tok          = 1'b1;
          set_hold         = 1'b1;
          s_nxt.stall      = 1'b0;
          s_nxt.st         = ST_SETUP;
          s_nxt.idx        = '0;
          s_nxt.data_stage = 1'b0;
          s_nxt.in_arm     = 1'b0;
          s_nxt.out_arm    = 1'b0;
        end
        TOK_IN: begin
          s_nxt.hs_stb = 1'b1;
          s_nxt.tx_len = '0;
          if (s_r.stall) begin
            s_nxt.hs_code = HS_STALL;
          end else if (s_r.data_stage && s_r.dir_in) begin
            if (s_r.in_arm) begin
              s_nxt.hs_code = HS_DATA;
              s_nxt.tx_len  = s_r.in_len;
              s_nxt.in_arm  = 1'b0;
            end else begin
              s_nxt.hs_code = HS_NAK;
            end
          end else if (hold_q) begin
            s_nxt.hs_code = HS_NAK;
          end else begin
            s_nxt.hs_code    = HS_DATA;
            s_nxt.data_stage = 1'b0;
            if (s_r.addr_vld) begin
              s_nxt.function_address_reg   = s_r.addr_pend;
              s_nxt.addr_vld = 1'b0;
            end
          end
        end
        TOK_OUT: begin
          s_nxt.st          = ST_OUT;
          s_nxt.idx         = '0;
          s_nxt.out_is_data = s_r.data_stage && !s_r.dir_in;
        end
        default: ;
      endcase
    end
    // Payload bytes
    if (rx_stb) begin
      if (s_r.st == ST_SETUP && s_r.idx < 7'(SETUP_LEN)) begin
        s_nxt.sbuf[s_r.idx[2:0]] = rx_byte;
        s_nxt.idx = s_r.idx + 7'h1;
      end else if (s_r.st == ST_OUT && s_r.out_is_data && s_r.out_arm
                   && !s_r.stall && s_r.idx < 7'(BUF_DEPTH)) begin
        s_nxt.obuf[s_r.idx[5:0]] = rx_byte;
        s_nxt.idx = s_r.idx + 7'h1;
      end
    end
    // End of data packet; a bad packet gets no answer at all
    if (pkt_end_stb) begin
      unique case (s_r.st)
        ST_SETUP: begin
          s_nxt.st = ST_IDLE;
          if (pkt_ok && s_r.idx == 7'(SETUP_LEN)) begin
            s_nxt.hs_stb     = 1'b1;
            s_nxt.hs_code    = HS_ACK;
            s_nxt.data_stage = (wlen != 16'h0);
            s_nxt.dir_in     = s_r.sbuf[SB_TYPE][TYPE_DIR];
            if (s_r.sbuf[SB_TYPE][6:5] == TYPE_VENDOR
                && s_r.sbuf[SB_REQ] == REQ_FW_LOAD) begin
              s_nxt.fw_stb = 1'b1;
              clr_hold     = 1'b1;
            end else if (!s_r.proc) begin
              s_nxt.auto_stb = 1'b1;
              clr_hold       = 1'b1;
            end else if (s_r.sbuf[SB_REQ] == REQ_SET_ADDR
                         && s_r.sbuf[SB_TYPE] == TYPE_STD_DEV) begin
              s_nxt.addr_pend = s_r.sbuf[SB_VALL][6:0];
              s_nxt.addr_vld  = 1'b1;
              clr_hold        = 1'b1;
            end else begin
              set_dav = 1'b1;
            end
          end
        end
        ST_OUT: begin
          s_nxt.st = ST_IDLE;
          if (pkt_ok) begin
            s_nxt.hs_stb = 1'b1;
            if (s_r.stall) begin
              s_nxt.hs_code = HS_STALL;
            end else if (s_r.out_is_data) begin
              if (s_r.out_arm) begin
                s_nxt.hs_code = HS_ACK;
                s_nxt.out_len = s_r.idx;
                s_nxt.out_arm = 1'b0;
              end else begin
                s_nxt.hs_code = HS_NAK;
              end
            end else if (hold_q) begin
              s_nxt.hs_code = HS_NAK;
            end else begin
              s_nxt.hs_code    = HS_ACK;
              s_nxt.data_stage = 1'b0;
            end
          end
        end
        ST_IDLE: ;
        default: s_nxt.st = ST_IDLE;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Register
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r    <= '0;
      s_r.st <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign prdata       = s_r.prdata;
  assign pready       = 1'b1;
  assign pslverr      = acc & ~hit;
  assign tx_byte      = s_r.tx_byte;
  assign hs_stb       = s_r.hs_stb;
  assign hs_code      = s_r.hs_code;
  assign tx_len       = s_r.tx_len;
  assign fw_load_stb  = s_r.fw_stb;
  assign auto_req_stb = s_r.auto_stb;
  assign setup_word   = s_r.sbuf;
  assign fn_addr      = s_r.function_address_reg;
  assign dptr_addr    = s_r.dptr;
  assign dptr_go      = s_r.dptr_go;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup_tok;
  assign setup_tok = tok_stb && tok_ep == EP_ZERO && tok_kind == TOK_SETUP;

  property p_store;
    rx_stb && s_r.st == ST_SETUP && s_r.idx < 7'(SETUP_LEN) && !setup_tok
      |=> s_r.sbuf[$past(s_r.idx[2:0])] == $past(rx_byte);
  endproperty
  a_store: assert property (p_store) else $error("setup byte lost");

  property p_tok;
    setup_tok |=> tok_q && s_r.st == ST_SETUP && s_r.idx == 7'h0;
  endproperty
  a_tok: assert property (p_tok) else $error("token flag not set");

  property p_dav;
    $rose(dav_q) |-> $past(pkt_end_stb && pkt_ok && s_r.st == ST_SETUP
      && s_r.idx == 7'(SETUP_LEN));
  endproperty
  a_dav: assert property (p_dav) else $error("early data flag");

  property p_bad;
    pkt_end_stb && !pkt_ok && s_r.st == ST_SETUP
      |=> !hs_stb && !$rose(dav_q);
  endproperty
  a_bad: assert property (p_bad) else $error("bad setup answered");

  property p_w1c;
    wr && paddr == OFS_REQ && pwdata[B_TOK] && !setup_tok |=> !tok_q;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_nak;
    tok_stb && tok_ep == EP_ZERO && tok_kind == TOK_IN && hold_q
      && !s_r.stall && !s_r.data_stage |=> hs_stb && hs_code == HS_NAK;
  endproperty
  a_nak: assert property (p_nak) else $error("status not held");

  property p_arm;
    tok_stb && tok_ep == EP_ZERO && tok_kind == TOK_IN && !s_r.in_arm
      && !s_r.stall && s_r.data_stage && s_r.dir_in
      |=> hs_stb && hs_code == HS_NAK;
  endproperty
  a_arm: assert property (p_arm) else $error("unarmed data acked");

  property p_nostall;
    pkt_end_stb && pkt_ok && s_r.st == ST_SETUP && s_r.idx == 7'(SETUP_LEN)
      |=> hs_stb && hs_code == HS_ACK;
  endproperty
  a_nostall: assert property (p_nostall) else $error("setup stalled");

  property p_unstall;
    setup_tok |=> !s_r.stall ##1 hold_q;
  endproperty
  a_unstall: assert property (p_unstall) else $error("stall kept");

  property p_fw;
    fw_load_stb |-> $past(s_r.sbuf[SB_REQ] == REQ_FW_LOAD
      && s_r.sbuf[SB_TYPE][6:5] == TYPE_VENDOR) && !$rose(dav_q);
  endproperty
  a_fw: assert property (p_fw) else $error("wrong load request");
endmodule // ep0_ctrl

// ==== verification/usb_host_model.sv ====
// Host-side packet engine model: tokens and setup data toward endpoint zero
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic     pclk,
  output logic          tok_stb,
  output ep0_pkg::tok_e tok_kind,
  output logic [3:0]    tok_ep,
  output logic          rx_stb,
  output logic [7:0]    rx_byte,
  output logic          pkt_end_stb,
  output logic          pkt_ok,
  output logic [5:0]    tx_idx
);
  import ep0_pkg::*;
  //----------------------------------------------------------------
  // Idle levels
  //----------------------------------------------------------------
  // Lines quiet at time zero; IN reads always start at byte 0
  initial begin
    tok_stb = 1'b0;
    tok_kind = TOK_NONE;
    tok_ep = 4'h0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    pkt_end_stb = 1'b0;
    pkt_ok = 1'b0;
    tx_idx = 6'h00;
  end
  // One-cycle token pulse, endpoint zero only
  task automatic send_tok(input tok_e k);
    @(posedge pclk);
    tok_stb <= 1'b1;
    tok_kind <= k;
    @(posedge pclk);
    tok_stb <= 1'b0;
    tok_kind <= TOK_NONE;
  endtask
  // Token, then n payload bytes low first, then end-of-packet with status
  task automatic send_pkt(input tok_e k, input logic [63:0] w, input int n, input logic ok);
    send_tok(k);
    for (int i = 0; i < n; i++) begin
      rx_stb <= 1'b1;
      rx_byte <= w[8*i +: 8];
      @(posedge pclk);
    end
    // Stale data is inverted so nothing can pass on a left-over value
    rx_stb <= 1'b0;
    rx_byte <= ~rx_byte;
    pkt_end_stb <= 1'b1;
    pkt_ok <= ok;
    @(posedge pclk);
    pkt_end_stb <= 1'b0;
    pkt_ok <= ~ok;
  endtask
  // Setup stage always carries the eight request bytes
  task automatic send_setup(input logic [63:0] w, input logic ok);
    send_pkt(TOK_SETUP, w, 8, ok);
  endtask
endmodule // usb_host_model

// ==== verification/tb_ep0_control_transfer.sv ====
// Self-checking bench for the endpoint-zero control engine
`timescale 1ns/1ps
module tb_ep0_control_transfer;
  import ep0_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        tok_stb, rx_stb, pkt_end_stb, pkt_ok, hs_stb, fw_stb, auto_stb;
  logic        dptr_go, irq_tok, irq_dat;
  tok_e        tok_kind;
  hs_e         hs_code;
  logic [3:0]  tok_ep;
  logic [7:0]  rx_byte, tx_byte, b;
  logic [5:0]  tx_idx;
  logic [6:0]  tx_len, fn_addr, adr;
  logic [63:0] setup_word;
  logic [15:0] dptr_addr, v;
  logic [8:0]  hs_q[$];   // Answers seen, {length, code}
  int          num_errors = 0, comparisons = 0, fw_n = 0, auto_n = 0, dp_n = 0;
  int          m_req = 0; // Model of the two request flags
  //----------------------------------------------------------------
  // Clock, parts and answer capture
  //----------------------------------------------------------------
  always #12.5 pclk = ~pclk;
  ep0_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tok_stb(tok_stb), .tok_kind(tok_kind), .tok_ep(tok_ep),
    .rx_stb(rx_stb), .rx_byte(rx_byte), .pkt_end_stb(pkt_end_stb), .pkt_ok(pkt_ok),
    .tx_idx(tx_idx), .tx_byte(tx_byte), .hs_stb(hs_stb), .hs_code(hs_code),
    .tx_len(tx_len), .fw_load_stb(fw_stb), .auto_req_stb(auto_stb),
    .setup_word(setup_word), .fn_addr(fn_addr), .dptr_addr(dptr_addr),
    .dptr_go(dptr_go), .irq_setup_token(irq_tok), .irq_setup_data(irq_dat));
  usb_host_model host_u (.pclk(pclk), .tok_stb(tok_stb), .tok_kind(tok_kind),
    .tok_ep(tok_ep), .rx_stb(rx_stb), .rx_byte(rx_byte), .pkt_end_stb(pkt_end_stb),
    .pkt_ok(pkt_ok), .tx_idx(tx_idx));
  // Pulses are counted at the edge that samples them
  always @(posedge pclk) begin
    if (hs_stb === 1'b1) hs_q.push_back({tx_len, hs_code});
    if (fw_stb === 1'b1) fw_n++;
    if (auto_stb === 1'b1) auto_n++;
    if (dptr_go === 1'b1) dp_n++;
  end
  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // APB transfer held until pready is sampled high or 16 cycles pass
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  // Oldest answer against its expected code, and its length for DATA answers only
  task automatic chk_hs(input hs_e c, input logic [6:0] len);
    logic [8:0] h;
    if (hs_q.size() == 0) chk("answer count", 1, 0);
    else begin
      h = hs_q.pop_front();
      chk("handshake", c, h[1:0]);
      if (c == HS_DATA) chk("tx length", len, h[8:2]);
    end
  endtask
  task automatic in_tok(input hs_e c, input logic [6:0] len);
    host_u.send_tok(TOK_IN);
    repeat (2) @(posedge pclk);
    chk_hs(c, len);
  endtask
  // OUT packet of n bytes, answer checked after end of packet
  task automatic out_pkt(input logic [63:0] w, input int n, input hs_e c);
    host_u.send_pkt(TOK_OUT, w, n, 1'b1);
    repeat (2) @(posedge pclk);
    chk_hs(c, 0);
  endtask
  // Setup stage; forwarded requests raise the data flag
  task automatic do_setup(input logic [7:0] t, input logic [7:0] r, input logic [15:0] val,
                          input logic [15:0] len, input logic ok, input logic fwd);
    logic [63:0] w;
    w = {len, 16'h0000, val, r, t};
    host_u.send_setup(w, ok);
    repeat (2) @(posedge pclk);
    m_req = m_req | 1;
    if (ok) begin
      chk_hs(HS_ACK, 0);
      chk("setup buffer", w, setup_word);
      if (fwd) m_req = m_req | 2;
    end
    else chk("bad setup answer", 0, hs_q.size());
    rd(OFS_REQ, m_req, "request flags");
  endtask
  task automatic clr(input int d);
    apb(1'b1, OFS_REQ, d);
    m_req = m_req & ~d;
    rd(OFS_REQ, m_req, "request flags");
  endtask
  task automatic stop_test;
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  //----------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    void'($urandom(41205));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CS, 0, "stall hold");
    apb(1'b1, OFS_VALID, 0);
    rd(OFS_VALID, VALID_BITS, "valid bits");
    rd(12'hff0, 0, "unmapped read");
    chk("slave error", 1, rerr);
    apb(1'b1, OFS_CFG, 1);
    apb(1'b1, OFS_EN, 3);
    v = 16'($urandom());
    do_setup(8'h80, 8'h06, v, 16'h0002, 1'b0, 1'b1);
    chk("data irq", 0, irq_dat);
    do_setup(8'h80, 8'h06, v, 16'h0002, 1'b1, 1'b1);
    chk("irq pair", 2'b11, {irq_tok, irq_dat});
    clr(0);
    clr(1);
    apb(1'b1, OFS_EN, 0);
    @(posedge pclk);
    chk("masked irq", 0, irq_dat);
    clr(3);
    in_tok(HS_NAK, 0);
    b = 8'($urandom());
    apb(1'b1, 12'h100, {24'h0, b});
    apb(1'b1, OFS_INBC, 2);
    in_tok(HS_DATA, 2);
    chk("in buffer byte", b, tx_byte);
    out_pkt(64'h0, 0, HS_NAK);
    do_setup(8'h00, 8'h09, 16'h0001, 16'h0000, 1'b1, 1'b1);
    apb(1'b1, OFS_CS, 3);
    in_tok(HS_STALL, 0);
    do_setup(8'h00, 8'h09, 16'h0001, 16'h0000, 1'b1, 1'b1);
    rd(OFS_CS, 2, "stall hold");
    in_tok(HS_NAK, 0);
    apb(1'b1, OFS_CS, 2);
    in_tok(HS_DATA, 0);
    do_setup(8'h00, 8'h07, v, 16'h0002, 1'b1, 1'b1);
    out_pkt(64'(v), 2, HS_NAK);
    apb(1'b1, OFS_OUTBC, 2);
    out_pkt(64'(v), 2, HS_ACK);
    rd(OFS_OUTBC, 2, "out count");
    rd(12'h200, {24'h0, v[7:0]}, "out buffer byte");
    in_tok(HS_NAK, 0);
    apb(1'b1, OFS_CS, 2);
    in_tok(HS_DATA, 0);
    clr(3);
    adr = 7'($urandom());
    do_setup(8'h00, REQ_SET_ADDR, {9'h0, adr}, 16'h0000, 1'b1, 1'b0);
    in_tok(HS_DATA, 0);
    chk("function address", adr, fn_addr);
    do_setup(8'h40, REQ_FW_LOAD, 16'h0000, 16'h0000, 1'b1, 1'b0);
    chk("firmware load", 1, fw_n);
    apb(1'b1, OFS_CFG, 0);
    do_setup(8'h80, 8'h06, 16'h0100, 16'h0012, 1'b1, 1'b0);
    chk("autonomous request", 1, auto_n);
    apb(1'b1, OFS_DPTR, {16'h0, v});
    repeat (2) @(posedge pclk);
    chk("data pointer", v, dptr_addr);
    chk("pointer strobe", 1, dp_n);
    stop_test;
  end
  // Watchdog far beyond the expected run length
  initial begin
    repeat (6000) @(posedge pclk);
    num_errors++;
    stop_test;
  end
endmodule // tb_ep0_control_transfer
